// [verilog/rx_pkg.sv]
// Shared constants and types of the asynchronous serial receiver
package rx_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_RCSTAT = 8'h18;
    localparam logic [7:0] IDX_RXDATA = 8'h1a;
    localparam logic [7:0] IDX_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_TXSTAT = 8'h98;
    localparam logic [7:0] IDX_DIVISOR = 8'h99;
    localparam logic [1:0] BYTE_LANE_BITS = 2'h0;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int RCF_BIT = 5;
    localparam int RECEIVE_INTERRUPT_ENABLE_BIT = 5;
    localparam int SERIAL_PORT_ENABLE_BIT = 7;
    localparam int RX9_BIT = 6;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int FRAMING_ERROR_BIT = 2;
    localparam int OVERRUN_ERROR_BIT = 1;
    localparam int SYNC_BIT = 4;
    localparam int HIGH_SPEED_BAUD_SELECT_BIT = 2;

    // ****************************************************************
    // Reset values and writable masks
    // ****************************************************************
    localparam logic [7:0] RCSTAT_RST = 8'h00;
    localparam logic [7:0] ENABLES_RST = 8'h00;
    localparam logic [7:0] TXSTAT_RST = 8'h02;
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    localparam logic [7:0] RCSTAT_WMASK = 8'hf0;
    localparam logic [7:0] TXSTAT_WMASK = 8'hf5;

    // ****************************************************************
    // Oversampling timing, in ticks of the sixteen-times clock
    // ****************************************************************
    localparam logic [3:0] SMP_FIRST = 4'h7;
    localparam logic [3:0] SMP_SECOND = 4'h8;
    localparam logic [3:0] SMP_LAST = 4'h9;
    localparam logic [3:0] BIT_END = 4'hf;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [1:0] LOW_SPEED_PRE = 2'h3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

    typedef struct packed {
        logic framing_error;
        logic ninth;
        logic [7:0] data;
    } fifo_entry_t;

endpackage

// [verilog/baud_tick_gen.sv]
// Divider that makes the sixteen-times oversampling enable pulse
`timescale 1ns/1ps
module baud_tick_gen (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic high_speed,
    input wire logic [7:0] divisor,
    output logic os_tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] pre;
        logic tick;
    } baud_state_t;

    baud_state_t c;
    baud_state_t n;

    // Low speed divides a further four, so divisor steps are coarser there
    always_comb begin
        n = c;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = divisor;
            n.pre = 2'h0;
        end else if (c.cnt == 8'h00) begin
            n.cnt = divisor;
            n.pre = c.pre + 2'h1;
            n.tick = high_speed || (c.pre == rx_pkg::LOW_SPEED_PRE);
        end else begin
            n.cnt = c.cnt - 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end

    assign os_tick = c.tick;
endmodule

// [verilog/rx_fifo.sv]
// Shift-style receive FIFO whose head entry sits in a register
`timescale 1ns/1ps
module rx_fifo #(
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic push,
    input rx_pkg::fifo_entry_t din,
    input wire logic pop,
    output rx_pkg::fifo_entry_t head,
    output logic full,
    output logic not_empty
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        rx_pkg::fifo_entry_t [DEPTH-1:0] e;
    } fifo_state_t;

    fifo_state_t c;
    fifo_state_t n;

    always_comb begin
        n = c;
        if (pop && (c.cnt != '0)) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                n.e[i] = c.e[i+1];
            end
            n.cnt = c.cnt - CW'(1);
        end
        if (push && (n.cnt < CW'(DEPTH))) begin
            n.e[n.cnt] = din;
            n.cnt = n.cnt + CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end

    assign head = c.e[0];
    assign full = (c.cnt == CW'(DEPTH));
    assign not_empty = (c.cnt != '0);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    second_entry_a: assert property (push && !pop && c.cnt == CW'(1) |=> c.e[1] == $past(din))
        else $error("second entry not stored behind the first");
    pop_order_a: assert property (pop && !push && c.cnt == CW'(2) |=> head == $past(c.e[1]))
        else $error("pop did not advance to the older waiting entry");
endmodule

// [verilog/async_serial_receiver.sv]
// Asynchronous serial receiver with APB register slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module async_serial_receiver #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rx_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    input wire logic sleep_mode,
    output logic rx_irq
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe[1];

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0] rxs;
        logic rx_level;
        logic armed;
        rx_pkg::rx_state_t st;
        logic [3:0] sub;
        logic [3:0] bits;
        logic [1:0] smp;
        logic [8:0] shift;
        logic overrun_error;
        logic [7:0] rcstat;
        logic [7:0] enables;
        logic [7:0] txstat;
        logic [7:0] divisor;
        logic [31:0] rdata;
        logic err;
        logic pop_ok;
    } rx_top_state_t;

    localparam rx_top_state_t RESET_STATE = '{
        rxs: 3'h7,
        rx_level: 1'b1,
        armed: 1'b0,
        st: rx_pkg::RX_IDLE,
        sub: 4'h0,
        bits: 4'h0,
        smp: 2'h0,
        shift: 9'h000,
        overrun_error: 1'b0,
        rcstat: rx_pkg::RCSTAT_RST,
        enables: rx_pkg::ENABLES_RST,
        txstat: rx_pkg::TXSTAT_RST,
        divisor: rx_pkg::DIVISOR_RST,
        rdata: 32'h0000_0000,
        err: 1'b0,
        pop_ok: 1'b0
    };

    rx_top_state_t c;
    rx_top_state_t n;

    logic os_tick;
    logic rx_active;
    logic vote;
    logic push;
    logic pop;
    logic fifo_full;
    logic rcf;
    rx_pkg::fifo_entry_t push_e;
    rx_pkg::fifo_entry_t head;
    logic [3:0] last_bit;
    logic [7:0] rd_val;
    logic rd_hit;
    logic [7:0] idx;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    baud_tick_gen u_baud (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_n),
        .run(rx_active),
        .high_speed(c.txstat[rx_pkg::HIGH_SPEED_BAUD_SELECT_BIT]),
        .divisor(c.divisor),
        .os_tick(os_tick)
    );

    rx_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_n),
        .push(push),
        .din(push_e),
        .pop(pop),
        .head(head),
        .full(fifo_full),
        .not_empty(rcf)
    );

    // ****************************************************************
    // Receive path and register file
    // ****************************************************************
    assign rx_active = c.rcstat[rx_pkg::SERIAL_PORT_ENABLE_BIT] && !c.txstat[rx_pkg::SYNC_BIT]
        && c.rcstat[rx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT] && !sleep_mode;
    assign vote = (c.smp[0] & c.smp[1]) | (c.smp[0] & c.rx_level)
        | (c.smp[1] & c.rx_level);
    assign last_bit = c.rcstat[rx_pkg::RX9_BIT] ? rx_pkg::LAST_BIT_9 : rx_pkg::LAST_BIT_8;
    // Upper address bits are checked below so no register aliases higher up
    assign idx = paddr[9:2];

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        case (idx)
            rx_pkg::IDX_FLAGS: rd_val[rx_pkg::RCF_BIT] = rcf;
            rx_pkg::IDX_RCSTAT: rd_val = {c.rcstat[7:4], 1'b0, head.framing_error, c.overrun_error,
                head.ninth};
            rx_pkg::IDX_RXDATA: rd_val = head.data;
            rx_pkg::IDX_ENABLES: rd_val = c.enables;
            rx_pkg::IDX_TXSTAT: rd_val = c.txstat;
            rx_pkg::IDX_DIVISOR: rd_val = c.divisor;
            default: rd_hit = 1'b0;
        endcase
        if ((paddr[1:0] != rx_pkg::BYTE_LANE_BITS) || (paddr[rx_pkg::ADDR_W-1:10] != '0)) begin
            rd_hit = 1'b0;
            rd_val = 8'h00;
        end
    end

    always_comb begin
        n = c;
        push = 1'b0;
        push_e = '0;
        pop = 1'b0;
        // Only the second stage reads the first; a change counts once stages two and three agree
        n.rxs = {c.rxs[1:0], rx_pin};
        if (c.rxs[1] == c.rxs[2]) begin
            n.rx_level = c.rxs[2];
        end
        if (!c.rcstat[rx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
            n.overrun_error = 1'b0;
        end
        if (!rx_active) begin
            n.st = rx_pkg::RX_IDLE;
            n.armed = 1'b0;
            n.sub = 4'h0;
        end else begin
            case (c.st)
                rx_pkg::RX_IDLE: begin
                    // Arming on a high level keeps a line stuck low from starting frames
                    if (c.rx_level) begin
                        n.armed = 1'b1;
                    end else if (c.armed) begin
                        n.st = rx_pkg::RX_START;
                        n.armed = 1'b0;
                        n.sub = 4'h0;
                    end
                end
                default: begin
                    if (os_tick) begin
                        n.sub = c.sub + 4'h1;
                        if (c.sub == rx_pkg::SMP_FIRST) begin
                            n.smp[0] = c.rx_level;
                        end
                        if (c.sub == rx_pkg::SMP_SECOND) begin
                            n.smp[1] = c.rx_level;
                        end
                        if (c.sub == rx_pkg::SMP_LAST) begin
                            case (c.st)
                                rx_pkg::RX_START: begin
                                    if (vote) begin
                                        n.st = rx_pkg::RX_IDLE;
                                    end
                                end
                                rx_pkg::RX_DATA: n.shift[c.bits] = vote;
                                rx_pkg::RX_STOP: begin
                                    n.st = rx_pkg::RX_IDLE;
                                    if (!c.overrun_error) begin
                                        if (fifo_full) begin
                                            n.overrun_error = 1'b1;
                                        end else begin
                                            push = 1'b1;
                                            push_e.framing_error = !vote;
                                            push_e.ninth = c.rcstat[rx_pkg::RX9_BIT]
                                                & c.shift[8];
                                            push_e.data = c.shift[7:0];
                                        end
                                    end
                                end
                                default: n.st = rx_pkg::RX_IDLE;
                            endcase
                        end
                        if (c.sub == rx_pkg::BIT_END) begin
                            if (c.st == rx_pkg::RX_START) begin
                                n.st = rx_pkg::RX_DATA;
                                n.bits = 4'h0;
                            end else if (c.bits == last_bit) begin
                                n.st = rx_pkg::RX_STOP;
                            end else begin
                                n.bits = c.bits + 4'h1;
                            end
                        end
                    end
                end
            endcase
        end
        // APB: read data and error are latched in setup, so the access phase is zero wait
        if (psel && !penable) begin
            n.rdata = {24'h00_0000, rd_val};
            n.err = !rd_hit;
            n.pop_ok = rd_hit && !pwrite && (idx == rx_pkg::IDX_RXDATA) && rcf;
        end
        if (psel && penable) begin
            n.pop_ok = 1'b0;
            pop = !pwrite && c.pop_ok;
            if (pwrite && pstrb[0] && rd_hit) begin
                case (idx)
                    rx_pkg::IDX_RCSTAT: n.rcstat = pwdata[7:0] & rx_pkg::RCSTAT_WMASK;
                    rx_pkg::IDX_ENABLES: n.enables = pwdata[7:0];
                    rx_pkg::IDX_TXSTAT: n.txstat = (pwdata[7:0] & rx_pkg::TXSTAT_WMASK)
                        | (rx_pkg::TXSTAT_RST & ~rx_pkg::TXSTAT_WMASK);
                    rx_pkg::IDX_DIVISOR: n.divisor = pwdata[7:0];
                    default: n.divisor = c.divisor;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            c <= RESET_STATE;
        end else begin
            c <= n;
        end
    end

    assign prdata = c.rdata;
    assign pslverr = c.err && psel && penable;
    assign pready = 1'b1;
    assign rx_irq = rcf && c.enables[rx_pkg::RECEIVE_INTERRUPT_ENABLE_BIT];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence stop_sample;
        c.st == rx_pkg::RX_STOP && os_tick && c.sub == rx_pkg::SMP_LAST;
    endsequence

    sequence bit_end;
        c.st == rx_pkg::RX_DATA && os_tick && c.sub == rx_pkg::BIT_END;
    endsequence

    bit_advance_a: assert property (bit_end and (c.bits != last_bit) |=>
        c.bits == $past(c.bits) + 4'h1)
        else $error("bit counter did not advance at bit end");
    disabled_idle_a: assert property (!rx_active |=> c.st == rx_pkg::RX_IDLE)
        else $error("receiver active while disabled");
    load_flag_a: assert property (stop_sample and (!c.overrun_error && !fifo_full) |=> rcf)
        else $error("completed frame did not raise the flag");
    irq_gate_a: assert property ($rose(rx_irq) |-> rcf && c.enables[rx_pkg::RECEIVE_INTERRUPT_ENABLE_BIT])
        else $error("interrupt without flag and enable");
    overrun_set_a: assert property (stop_sample and (!c.overrun_error && fifo_full) |=> c.overrun_error)
        else $error("overrun not flagged on full FIFO");
    overrun_hold_a: assert property (c.overrun_error && c.rcstat[rx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT] |=> c.overrun_error)
        else $error("overrun cleared while receive enabled");
    overrun_block_a: assert property (c.overrun_error |-> !push)
        else $error("FIFO loaded during overrun");
    framing_a: assert property (stop_sample and (!c.overrun_error && !fifo_full) |->
        push && push_e.framing_error == ((c.smp == 2'b00) || (c.smp != 2'b11 && !c.rx_level)))
        else $error("framing error not matching stop sample");
    start_reject_a: assert property (c.st == rx_pkg::RX_START && os_tick
        && c.sub == rx_pkg::SMP_LAST && vote |=> c.st == rx_pkg::RX_IDLE)
        else $error("high start sample not rejected");
    reserved_zero_a: assert property (psel && !penable
        && (idx == rx_pkg::IDX_RCSTAT || idx == rx_pkg::IDX_TXSTAT)
        |=> prdata[3] == 1'b0)
        else $error("unimplemented status bit read nonzero");
endmodule

// [test/serial_tx_model.sv]
// Behavioural far-end transmitter that drives the receive line
`timescale 1ns/1ps
module serial_tx_model #(
    parameter int BIT_CYC = 32
) (
    input wire logic sys_clk,
    output logic rx_pin
);
    // Bit length in clocks; the bench may change it for the slower baud mode
    int bit_cyc = BIT_CYC;

    // Line idles high between frames
    initial begin
        rx_pin = 1'b1;
    end

    task automatic hold_bit(input logic level, input int cyc);
        rx_pin <= level;
        repeat (cyc) @(posedge sys_clk);
    endtask

    // Start, data least significant first, stop, then one idle bit so a new edge follows
    task automatic send(input logic [8:0] word, input logic nine, input logic stop_level);
        int i;
        @(posedge sys_clk);
        hold_bit(1'b0, bit_cyc);
        for (i = 0; i < (nine ? 9 : 8); i++) begin
            hold_bit(word[i], bit_cyc);
        end
        hold_bit(stop_level, bit_cyc);
        hold_bit(1'b1, bit_cyc);
    endtask

    // Low pulse too short to survive the mid-bit vote
    task automatic glitch();
        @(posedge sys_clk);
        hold_bit(1'b0, bit_cyc / 4);
        hold_bit(1'b1, 2 * bit_cyc);
    endtask
endmodule

// [test/tb_async_serial_receiver.sv]
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
module tb_async_serial_receiver;
    // ****************************************************************
    // Signals
    // ****************************************************************
    // Divisor 1 with high speed gives a tick every 2 clocks, 32 clocks a bit
    localparam int BIT_CYC = 32;
    localparam int LIMIT = 30000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [rx_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic sleep_mode = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_pin;
    logic rx_irq;
    logic [32:0] exp_q[$];
    logic [7:0] b [0:4];
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2 sys_clk = ~sys_clk;

    async_serial_receiver #(.FIFO_DEPTH(2)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .sleep_mode(sleep_mode), .rx_irq(rx_irq)
    );

    serial_tx_model #(.BIT_CYC(BIT_CYC)) i_tx (.sys_clk(sys_clk), .rx_pin(rx_pin));

    // ****************************************************************
    // Bus tasks and comparisons
    // ****************************************************************
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [1:0] lane,
                        input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, lane};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        xfer(1'b1, idx, 2'h0, {24'h0, val});
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] val);
        exp_q.push_back({1'b0, 24'h0, val});
        xfer(1'b0, idx, 2'h0, 32'h0);
    endtask

    task automatic rd_err(input logic [7:0] idx, input logic [1:0] lane);
        exp_q.push_back({1'b1, 32'h0});
        xfer(1'b0, idx, lane, 32'h0);
    endtask

    task automatic check_word(input logic [32:0] expv, input logic [32:0] got);
        cmp_count++;
        if (got !== expv) begin
            err_total++;
            $display("mismatch at %0t: expected %h, got %h", $time, expv, got);
        end
    endtask

    task automatic check_irq(input logic expv);
        @(posedge sys_clk);
        #1;
        cmp_count++;
        if (rx_irq !== expv) begin
            err_total++;
            $display("mismatch at %0t: expected %h, got %h", $time, expv, rx_irq);
        end
    endtask

    task automatic stop_test();
        if (exp_q.size() != 0) err_total++;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Read results are taken in the access cycle, oldest note first
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                err_total++;
            end else begin
                check_word(exp_q.pop_front(), {pslverr, prdata});
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            stop_test();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(32'h8015de6e));
        for (int k = 0; k < 5; k++) b[k] = 8'($urandom());
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        rd(rx_pkg::IDX_RCSTAT, rx_pkg::RCSTAT_RST);
        rd(rx_pkg::IDX_RXDATA, 8'h00);
        rd(rx_pkg::IDX_ENABLES, rx_pkg::ENABLES_RST);
        rd(rx_pkg::IDX_TXSTAT, rx_pkg::TXSTAT_RST);
        rd(rx_pkg::IDX_DIVISOR, rx_pkg::DIVISOR_RST);
        rd_err(8'h01, 2'h0);
        rd_err(rx_pkg::IDX_RCSTAT, 2'h1);
        // A write without the low byte strobe must leave the register alone
        pstrb <= 4'he;
        wr(rx_pkg::IDX_DIVISOR, 8'h55);
        pstrb <= 4'hf;
        rd(rx_pkg::IDX_DIVISOR, rx_pkg::DIVISOR_RST);
        // Only implemented bits stick, status bits stay as hardware keeps them
        wr(rx_pkg::IDX_RCSTAT, 8'hff);
        rd(rx_pkg::IDX_RCSTAT, 8'hf0);
        wr(rx_pkg::IDX_TXSTAT, 8'hff);
        rd(rx_pkg::IDX_TXSTAT, 8'hf7);
        wr(rx_pkg::IDX_FLAGS, 8'hff);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        // Set-up order: divisor, speed and async select, then enable
        wr(rx_pkg::IDX_DIVISOR, 8'h01);
        wr(rx_pkg::IDX_TXSTAT, 8'h04);
        wr(rx_pkg::IDX_RCSTAT, 8'h80);
        i_tx.send({1'b0, b[0]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        wr(rx_pkg::IDX_RCSTAT, 8'h90);
        i_tx.send({1'b0, b[0]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_FLAGS, 8'h20);
        check_irq(1'b0);
        wr(rx_pkg::IDX_ENABLES, 8'h20);
        check_irq(1'b1);
        rd(rx_pkg::IDX_RCSTAT, 8'h90);
        rd(rx_pkg::IDX_RXDATA, b[0]);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        check_irq(1'b0);
        // Three frames with no reads: the third overruns
        for (int k = 1; k < 4; k++) i_tx.send({1'b0, b[k]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_RCSTAT, 8'h92);
        rd(rx_pkg::IDX_RXDATA, b[1]);
        rd(rx_pkg::IDX_RXDATA, b[2]);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        i_tx.send({1'b0, b[4]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        rd(rx_pkg::IDX_RCSTAT, 8'h92);
        wr(rx_pkg::IDX_RCSTAT, 8'h80);
        rd(rx_pkg::IDX_RCSTAT, 8'h80);
        wr(rx_pkg::IDX_RCSTAT, 8'h90);
        i_tx.send({1'b0, b[4]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_RXDATA, b[4]);
        // Nine-bit frames, the first with a low stop bit
        wr(rx_pkg::IDX_RCSTAT, 8'hd0);
        i_tx.send({1'b1, b[1]}, 1'b1, 1'b0);
        i_tx.send({1'b0, b[3]}, 1'b1, 1'b1);
        rd(rx_pkg::IDX_RCSTAT, 8'hd5);
        rd(rx_pkg::IDX_RXDATA, b[1]);
        rd(rx_pkg::IDX_RCSTAT, 8'hd0);
        rd(rx_pkg::IDX_RXDATA, b[3]);
        wr(rx_pkg::IDX_RCSTAT, 8'h90);
        // No reception while asleep or in synchronous mode
        sleep_mode <= 1'b1;
        i_tx.send({1'b0, b[2]}, 1'b0, 1'b1);
        sleep_mode <= 1'b0;
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        wr(rx_pkg::IDX_TXSTAT, 8'h14);
        i_tx.send({1'b0, b[2]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        wr(rx_pkg::IDX_TXSTAT, 8'h04);
        // A short low pulse must not start a frame
        i_tx.glitch();
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        i_tx.send({1'b0, b[2]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_RXDATA, b[2]);
        rd(rx_pkg::IDX_FLAGS, 8'h00);
        // Low speed divides by four more, so a bit lasts four times as long
        wr(rx_pkg::IDX_TXSTAT, 8'h00);
        i_tx.bit_cyc = 4 * BIT_CYC;
        i_tx.send({1'b0, b[3]}, 1'b0, 1'b1);
        rd(rx_pkg::IDX_RXDATA, b[3]);
        repeat (4) @(posedge sys_clk);
        stop_test();
    end
endmodule
